// ---- hdl/cgr_gate_regs.sv ----
/*
 * Register bank gating the internal clocks of the divider, calibration and
 * monitoring logic, plus the spare update bytes, oscillator calibration code
 * and input validation settings.
 * Assumes the serial management port presents single-cycle byte reads and
 * writes in the CLK_I domain; output divider enable and power-up bits come
 * from their own registers elsewhere in the same domain.
 */
// How it works
// R01 - Four prescaler fraction gates, input 3 on top; 1 stops, 0 runs.
// R02 - Bit 5 stops the feedback fraction clock when 1, runs it when 0.
// R03 - Bit 1 of lock-loss byte stops the lock-loss detector clock when set.
// R04 - Four bits stop each input's signal-loss detector clock; 0 keeps it working.
// R05 - Five offset-monitor clock gates: bits 3..0 inputs, bit 4 crystal reference.
// R06 - Five offset-monitor divider gates, same mapping; all zero for normal use.
// R07 - Calibration block and force fields share a byte; zero means normal calibration.
// R08 - Five output divider gates; a set bit stops that divider's clock.
// R09 - Bit 5 of divider byte disables the feedback divider when set.
// R10 - Bit 6 of divider byte blocks feedback divider calibration when set.
// R11 - Two spare read/write bytes, no function, used during live updates.
// R12 - Output divider runs only if enabled, powered up and not gated.
// R13 - Gate changes take effect on clock edges, never truncating a pulse.
`timescale 1ns/1ps
`default_nettype none

module cgr_gate_regs
	import cgr_pkg::*;
(
	// Clock and reset
	input  wire logic                    CLK_I,
	input  wire logic                    SYS_RST_I,
	// Register port
	input  wire logic [ADDR_W-1:0]       REG_ADDR_I,
	input  wire logic                    REG_WR_I,
	input  wire logic [DATA_W-1:0]       REG_WDATA_I,
	input  wire logic                    REG_RD_I,
	output logic      [DATA_W-1:0]       REG_RDATA_O,
	// Output divider qualifiers from neighbouring registers
	input  wire logic [NUM_OUT_DIVS-1:0] OUTPUT_DIVIDER_ENABLE_I,
	input  wire logic [NUM_OUT_DIVS-1:0] OUTPUT_DIVIDER_POWERUP_I,
	// Fractional section run enables
	output logic      [NUM_INPUTS-1:0]   PRESCALER_FRACTION_RUN_O,
	output logic                         FEEDBACK_FRACTION_RUN_O,
	// Monitor run enables
	output logic                         LOCK_LOSS_DETECTOR_RUN_O,
	output logic      [NUM_INPUTS-1:0]   SIGNAL_LOSS_DETECTOR_RUN_O,
	output logic      [NUM_MONITORS-1:0] FREQ_OFFSET_RUN_O,
	output logic      [NUM_MONITORS-1:0] FREQ_OFFSET_DIVIDER_RUN_O,
	// Calibration controls
	output logic      [CAL_W-1:0]        CALIBRATION_BLOCK_O,
	output logic      [CAL_W-1:0]        CALIBRATION_FORCE_O,
	output logic                         FEEDBACK_CALIBRATION_ALLOW_O,
	// Divider run enables
	output logic      [NUM_OUT_DIVS-1:0] OUTPUT_DIVIDER_RUN_O,
	output logic                         FEEDBACK_DIVIDER_RUN_O,
	// Plain settings
	output logic                         OUT4_LOAD_AUTODISABLE_O,
	output logic      [DATA_W-1:0]       SPARE_UPDATE_A_O,
	output logic      [DATA_W-1:0]       SPARE_UPDATE_B_O,
	output logic      [CAL_CODE_W-1:0]   OSCILLATOR_CAL_CODE_O,
	output logic      [VAL_DIV0_W-1:0]   VALIDATION_DIV_CTRL0_O,
	output logic                         VALIDATION_DIV_CTRL1_O,
	output logic      [NUM_INPUTS-1:0]   VALIDATION_POWERUP_SKIP_O,
	output logic                         INPUT_VALIDATION_ON_O,
	output logic      [DATA_W-1:0]       INPUT_VALIDATION_PERIOD_O
);

	// ============================================================
	// Helpers
	function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
		return REG_WR_I && (REG_ADDR_I == ofs);
	endfunction

	// ============================================================
	// Stored fields
	logic                    out4_load_autodisable_r;
	logic [DATA_W-1:0]       spare_a_r;
	logic [DATA_W-1:0]       spare_b_r;

	// Clock gate bits, a 1 stops the clock, then calibration and validation fields
	logic [NUM_INPUTS-1:0]   prescaler_fraction_gate_r;
	logic                    feedback_fraction_gate_r;
	logic                    lock_loss_gate_r;
	logic [NUM_INPUTS-1:0]   signal_loss_gate_r;
	logic [NUM_MONITORS-1:0] freq_offset_gate_r;
	logic [NUM_MONITORS-1:0] freq_offset_divider_gate_r;
	logic [CAL_W-1:0]        calibration_block_r;
	logic [CAL_W-1:0]        calibration_force_r;
	logic [NUM_OUT_DIVS-1:0] output_divider_gate_r;
	logic                    feedback_divider_gate_r;
	logic                    feedback_calibration_block_r;
	logic [CAL_CODE_W-1:0]   oscillator_cal_code_r;
	logic [VAL_DIV0_W-1:0]   val_div0_r;
	logic                    val_div1_r;
	logic [NUM_INPUTS-1:0]   val_pwrup_skip_r;
	logic                    input_validation_on_r;
	logic [DATA_W-1:0]       input_validation_period_r;

	// Read path
	logic [DATA_W-1:0]       rdata_nxt;

	// ============================================================
	// Fractional section gates
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			prescaler_fraction_gate_r <= RST_BYTE[NUM_INPUTS-1:0];
			feedback_fraction_gate_r  <= 1'b0;
		end else if (wr_hit(OFS_FRACTIONAL_GATES)) begin
			prescaler_fraction_gate_r <= REG_WDATA_I[POS_PRESCALER_FRAC_LSB +: NUM_INPUTS]; // R01
			feedback_fraction_gate_r  <= REG_WDATA_I[POS_FEEDBACK_FRAC];                   // R02
		end
	end

	// ============================================================
	// Monitor gates
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			lock_loss_gate_r           <= 1'b0;
			signal_loss_gate_r         <= RST_BYTE[NUM_INPUTS-1:0];
			freq_offset_gate_r         <= RST_BYTE[NUM_MONITORS-1:0];
			freq_offset_divider_gate_r <= RST_BYTE[NUM_MONITORS-1:0];
		end else begin
			if (wr_hit(OFS_LOCK_LOSS_GATE)) begin
				lock_loss_gate_r <= REG_WDATA_I[POS_LOCK_LOSS]; // R03
			end
			if (wr_hit(OFS_SIGNAL_LOSS_GATES)) begin
				signal_loss_gate_r <= REG_WDATA_I[POS_SIGNAL_LOSS_LSB +: NUM_INPUTS]; // R04
			end
			if (wr_hit(OFS_FREQ_OFFSET_GATES)) begin
				freq_offset_gate_r <= REG_WDATA_I[POS_FREQ_OFFSET_LSB +: NUM_MONITORS]; // R05
			end
			if (wr_hit(OFS_FREQ_OFFSET_DIV_GATES)) begin
				freq_offset_divider_gate_r <= REG_WDATA_I[POS_FREQ_OFFSET_LSB +: NUM_MONITORS]; // R06
			end
		end
	end

	// ============================================================
	// Calibration override and divider gates
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			calibration_block_r          <= RST_BYTE[CAL_W-1:0];
			calibration_force_r          <= RST_BYTE[CAL_W-1:0];
			output_divider_gate_r        <= RST_BYTE[NUM_OUT_DIVS-1:0];
			feedback_divider_gate_r      <= 1'b0;
			feedback_calibration_block_r <= 1'b0;
		end else begin
			if (wr_hit(OFS_CALIBRATION_OVERRIDE)) begin
				calibration_block_r <= REG_WDATA_I[POS_CAL_BLOCK_LSB +: CAL_W]; // R07
				calibration_force_r <= REG_WDATA_I[POS_CAL_FORCE_LSB +: CAL_W]; // R07
			end
			if (wr_hit(OFS_DIVIDER_GATES)) begin
				output_divider_gate_r        <= REG_WDATA_I[POS_OUT_DIV_LSB +: NUM_OUT_DIVS]; // R08
				feedback_divider_gate_r      <= REG_WDATA_I[POS_FEEDBACK_DIV];              // R09
				feedback_calibration_block_r <= REG_WDATA_I[POS_FEEDBACK_CAL];              // R10
			end
		end
	end

	// ============================================================
	// Spare update bytes and auto-disable
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			spare_a_r               <= RST_BYTE;
			spare_b_r               <= RST_BYTE;
			out4_load_autodisable_r <= 1'b0;
		end else begin
			if (wr_hit(OFS_SPARE_UPDATE_A)) begin
				spare_a_r <= REG_WDATA_I; // R11
			end
			if (wr_hit(OFS_SPARE_UPDATE_B)) begin
				spare_b_r <= REG_WDATA_I; // R11
			end
			if (wr_hit(OFS_OUT4_LOAD_AUTODISABLE)) begin
				out4_load_autodisable_r <= REG_WDATA_I[POS_OUT4_LOAD_AUTODIS];
			end
		end
	end

	// ============================================================
	// Oscillator calibration code and input validation
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			oscillator_cal_code_r     <= RST_CAL_CODE;
			val_div0_r                <= RST_BYTE[VAL_DIV0_W-1:0];
			val_div1_r                <= 1'b0;
			val_pwrup_skip_r          <= RST_BYTE[NUM_INPUTS-1:0];
			input_validation_on_r     <= 1'b0;
			input_validation_period_r <= RST_BYTE;
		end else begin
			if (wr_hit(OFS_OSC_CAL_CODE_LOW)) begin
				oscillator_cal_code_r[DATA_W-1:0] <= REG_WDATA_I;
			end
			if (wr_hit(OFS_OSC_CAL_CODE_HIGH)) begin
				oscillator_cal_code_r[CAL_CODE_W-1:DATA_W] <= REG_WDATA_I[POS_CAL_HIGH_LSB +: CAL_HIGH_W];
			end
			if (wr_hit(OFS_VALIDATION_DIV_CTRL)) begin
				val_div0_r <= REG_WDATA_I[POS_VAL_DIV0_LSB +: VAL_DIV0_W];
				val_div1_r <= REG_WDATA_I[POS_VAL_DIV1];
			end
			if (wr_hit(OFS_VALIDATION_PWRUP_SKIP)) begin
				val_pwrup_skip_r <= REG_WDATA_I[POS_VAL_PWRUP_LSB +: NUM_INPUTS];
			end
			if (wr_hit(OFS_INPUT_VALIDATION_ON)) begin
				input_validation_on_r <= REG_WDATA_I[POS_VAL_ON];
			end
			if (wr_hit(OFS_INPUT_VALIDATION_TIME)) begin
				input_validation_period_r <= REG_WDATA_I;
			end
		end
	end

	// ============================================================
	// Read decode: unused bits and unmapped addresses read zero
	always_comb begin
		rdata_nxt = RD_UNMAPPED;
		unique case (REG_ADDR_I)
			OFS_OUT4_LOAD_AUTODISABLE: begin
				rdata_nxt[POS_OUT4_LOAD_AUTODIS] = out4_load_autodisable_r;
			end
			OFS_SPARE_UPDATE_A:        rdata_nxt = spare_a_r;
			OFS_SPARE_UPDATE_B:        rdata_nxt = spare_b_r;
			OFS_FRACTIONAL_GATES: begin
				rdata_nxt[POS_PRESCALER_FRAC_LSB +: NUM_INPUTS] = prescaler_fraction_gate_r;
				rdata_nxt[POS_FEEDBACK_FRAC]                    = feedback_fraction_gate_r;
			end
			OFS_LOCK_LOSS_GATE: begin
				rdata_nxt[POS_LOCK_LOSS] = lock_loss_gate_r;
			end
			OFS_SIGNAL_LOSS_GATES: begin
				rdata_nxt[POS_SIGNAL_LOSS_LSB +: NUM_INPUTS] = signal_loss_gate_r;
			end
			OFS_FREQ_OFFSET_GATES: begin
				rdata_nxt[POS_FREQ_OFFSET_LSB +: NUM_MONITORS] = freq_offset_gate_r;
			end
			OFS_FREQ_OFFSET_DIV_GATES: begin
				rdata_nxt[POS_FREQ_OFFSET_LSB +: NUM_MONITORS] = freq_offset_divider_gate_r;
			end
			OFS_CALIBRATION_OVERRIDE: begin
				rdata_nxt[POS_CAL_BLOCK_LSB +: CAL_W] = calibration_block_r;
				rdata_nxt[POS_CAL_FORCE_LSB +: CAL_W] = calibration_force_r;
			end
			OFS_DIVIDER_GATES: begin
				rdata_nxt[POS_OUT_DIV_LSB +: NUM_OUT_DIVS] = output_divider_gate_r;
				rdata_nxt[POS_FEEDBACK_DIV]                = feedback_divider_gate_r;
				rdata_nxt[POS_FEEDBACK_CAL]                = feedback_calibration_block_r;
			end
			OFS_OSC_CAL_CODE_LOW:      rdata_nxt = oscillator_cal_code_r[DATA_W-1:0];
			OFS_OSC_CAL_CODE_HIGH: begin
				rdata_nxt[POS_CAL_HIGH_LSB +: CAL_HIGH_W] = oscillator_cal_code_r[CAL_CODE_W-1:DATA_W];
			end
			OFS_VALIDATION_DIV_CTRL: begin
				rdata_nxt[POS_VAL_DIV0_LSB +: VAL_DIV0_W] = val_div0_r;
				rdata_nxt[POS_VAL_DIV1]                   = val_div1_r;
			end
			OFS_VALIDATION_PWRUP_SKIP: begin
				rdata_nxt[POS_VAL_PWRUP_LSB +: NUM_INPUTS] = val_pwrup_skip_r;
			end
			OFS_INPUT_VALIDATION_ON: begin
				rdata_nxt[POS_VAL_ON] = input_validation_on_r;
			end
			OFS_INPUT_VALIDATION_TIME: rdata_nxt = input_validation_period_r;
			default:                   rdata_nxt = RD_UNMAPPED;
		endcase
	end

	// Read data holds until the next read strobe
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			REG_RDATA_O <= RD_UNMAPPED;
		end else if (REG_RD_I) begin
			REG_RDATA_O <= rdata_nxt;
		end
	end

	// ============================================================
	// Gated clock enables, each switched on a clock edge
	cgr_clock_gate #(.WIDTH(NUM_INPUTS)) u_prescaler_gate (
		.clk_i      (CLK_I),
		.rst_i      (SYS_RST_I),
		.gate_off_i (prescaler_fraction_gate_r), // R01 R13
		.run_o      (PRESCALER_FRACTION_RUN_O)
	);

	cgr_clock_gate #(.WIDTH(1)) u_feedback_fraction_gate (
		.clk_i      (CLK_I),
		.rst_i      (SYS_RST_I),
		.gate_off_i (feedback_fraction_gate_r), // R02 R13
		.run_o      (FEEDBACK_FRACTION_RUN_O)
	);

	cgr_clock_gate #(.WIDTH(1)) u_feedback_divider_gate (
		.clk_i      (CLK_I),
		.rst_i      (SYS_RST_I),
		.gate_off_i (feedback_divider_gate_r), // R09 R13
		.run_o      (FEEDBACK_DIVIDER_RUN_O)
	);

	cgr_clock_gate #(.WIDTH(1 + NUM_INPUTS)) u_loss_gate (
		.clk_i      (CLK_I),
		.rst_i      (SYS_RST_I),
		.gate_off_i ({lock_loss_gate_r, signal_loss_gate_r}), // R03 R04
		.run_o      ({LOCK_LOSS_DETECTOR_RUN_O, SIGNAL_LOSS_DETECTOR_RUN_O})
	);

	cgr_clock_gate #(.WIDTH(2 * NUM_MONITORS)) u_offset_gate (
		.clk_i      (CLK_I),
		.rst_i      (SYS_RST_I),
		.gate_off_i ({freq_offset_gate_r, freq_offset_divider_gate_r}), // R05 R06
		.run_o      ({FREQ_OFFSET_RUN_O, FREQ_OFFSET_DIVIDER_RUN_O})
	);

	cgr_div_enable u_div_enable (
		.clk_i      (CLK_I),
		.rst_i      (SYS_RST_I),
		.enable_i   (OUTPUT_DIVIDER_ENABLE_I),
		.powerup_i  (OUTPUT_DIVIDER_POWERUP_I),
		.gate_off_i (output_divider_gate_r), // R08 R12
		.run_o      (OUTPUT_DIVIDER_RUN_O)
	);

	// ============================================================
	// Plain setting outputs
	assign CALIBRATION_BLOCK_O          = calibration_block_r; // R07
	assign CALIBRATION_FORCE_O          = calibration_force_r; // R07
	assign FEEDBACK_CALIBRATION_ALLOW_O = ~feedback_calibration_block_r; // R10

	// Spare bytes and auto-disable
	assign OUT4_LOAD_AUTODISABLE_O      = out4_load_autodisable_r;
	assign SPARE_UPDATE_A_O             = spare_a_r;
	assign SPARE_UPDATE_B_O             = spare_b_r;

	// Calibration code and input validation
	assign OSCILLATOR_CAL_CODE_O        = oscillator_cal_code_r;
	assign VALIDATION_DIV_CTRL0_O       = val_div0_r;
	assign VALIDATION_DIV_CTRL1_O       = val_div1_r;
	assign VALIDATION_POWERUP_SKIP_O    = val_pwrup_skip_r;
	assign INPUT_VALIDATION_ON_O        = input_validation_on_r;
	assign INPUT_VALIDATION_PERIOD_O    = input_validation_period_r;

endmodule // cgr_gate_regs

`default_nettype wire

// ---- pkg/cgr_pkg.sv ----
/*
 * Constants for the divider, monitor and calibration clock gate register bank:
 * register offsets, field positions, field widths and reset values.
 * Assumes an 8-bit register port with 16-bit byte addresses in the register clock domain.
 */
`default_nettype none

package cgr_pkg;

	// ============================================================
	// Register port geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// ============================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_OUT4_LOAD_AUTODISABLE = 16'h0a2c;
	localparam logic [ADDR_W-1:0] OFS_SPARE_UPDATE_A        = 16'h0b24;
	localparam logic [ADDR_W-1:0] OFS_SPARE_UPDATE_B        = 16'h0b25;
	localparam logic [ADDR_W-1:0] OFS_FRACTIONAL_GATES      = 16'h0b44;
	localparam logic [ADDR_W-1:0] OFS_LOCK_LOSS_GATE        = 16'h0b45;
	localparam logic [ADDR_W-1:0] OFS_SIGNAL_LOSS_GATES     = 16'h0b46;
	localparam logic [ADDR_W-1:0] OFS_FREQ_OFFSET_GATES     = 16'h0b47;
	localparam logic [ADDR_W-1:0] OFS_FREQ_OFFSET_DIV_GATES = 16'h0b48;
	localparam logic [ADDR_W-1:0] OFS_CALIBRATION_OVERRIDE  = 16'h0b49;
	localparam logic [ADDR_W-1:0] OFS_DIVIDER_GATES         = 16'h0b4a;
	localparam logic [ADDR_W-1:0] OFS_OSC_CAL_CODE_LOW      = 16'h0b57;
	localparam logic [ADDR_W-1:0] OFS_OSC_CAL_CODE_HIGH     = 16'h0b58;
	localparam logic [ADDR_W-1:0] OFS_VALIDATION_DIV_CTRL   = 16'h0c02;
	localparam logic [ADDR_W-1:0] OFS_VALIDATION_PWRUP_SKIP = 16'h0c03;
	localparam logic [ADDR_W-1:0] OFS_INPUT_VALIDATION_ON   = 16'h0c07;
	localparam logic [ADDR_W-1:0] OFS_INPUT_VALIDATION_TIME = 16'h0c08;

	// ============================================================
	// Counts of gated targets and calibration field widths
	localparam int NUM_INPUTS   = 4;
	localparam int NUM_MONITORS = 5;
	localparam int NUM_OUT_DIVS = 5;
	localparam int CAL_W        = 2;
	localparam int CAL_CODE_W   = 12;

	// ============================================================
	// Field positions and widths
	localparam int POS_OUT4_LOAD_AUTODIS  = 3;
	localparam int POS_PRESCALER_FRAC_LSB = 0;
	localparam int POS_FEEDBACK_FRAC      = 5;
	localparam int POS_LOCK_LOSS          = 1;
	localparam int POS_SIGNAL_LOSS_LSB    = 0;
	localparam int POS_FREQ_OFFSET_LSB    = 0;
	localparam int POS_CAL_BLOCK_LSB      = 0;
	localparam int POS_CAL_FORCE_LSB      = 2;
	localparam int POS_OUT_DIV_LSB        = 0;
	localparam int POS_FEEDBACK_DIV       = 5;
	localparam int POS_FEEDBACK_CAL       = 6;
	localparam int POS_CAL_HIGH_LSB       = 0;
	localparam int CAL_HIGH_W             = 4;
	localparam int POS_VAL_DIV0_LSB       = 0;
	localparam int VAL_DIV0_W             = 3;
	localparam int POS_VAL_DIV1           = 4;
	localparam int POS_VAL_PWRUP_LSB      = 0;
	localparam int POS_VAL_ON             = 0;

	// ============================================================
	// Reset values: every gate clear so all gated clocks run; output dividers also need enable and power-up
	localparam logic [DATA_W-1:0]     RST_BYTE     = 8'h00;
	localparam logic [CAL_CODE_W-1:0] RST_CAL_CODE = 12'h000;
	localparam logic [DATA_W-1:0]     RD_UNMAPPED  = 8'h00;

endpackage

`default_nettype wire

// ---- hdl/cgr_clock_gate.sv ----
/*
 * Glitch-free gate enable stage: turns a vector of gate-off bits into
 * registered run enables, one per gated clock.
 * Assumes the gated clocks are built as clock enables in the CLK_I domain,
 * so a registered enable changes only on a clock edge and never cuts a pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module cgr_clock_gate #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Gate control
	input  wire logic [WIDTH-1:0] gate_off_i,
	// Run enables
	output logic      [WIDTH-1:0] run_o
);

	// ============================================================
	// Enable register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_o <= '1;
		end else begin
			run_o <= ~gate_off_i; // R13
		end
	end

endmodule // cgr_clock_gate

`default_nettype wire

// ---- hdl/cgr_div_enable.sv ----
/*
 * Output divider run qualifier: a divider runs only when enabled, powered up
 * and not clock gated.
 * Assumes enable and power-up bits come from registers in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module cgr_div_enable
	import cgr_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Qualifying terms
	input  wire logic [NUM_OUT_DIVS-1:0] enable_i,
	input  wire logic [NUM_OUT_DIVS-1:0] powerup_i,
	input  wire logic [NUM_OUT_DIVS-1:0] gate_off_i,
	// Run result
	output logic      [NUM_OUT_DIVS-1:0] run_o
);

	// ============================================================
	// Three-way qualification, registered so a change lands on an edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_o <= '0;
		end else begin
			run_o <= enable_i & powerup_i & ~gate_off_i; // R12 R13
		end
	end

endmodule // cgr_div_enable

`default_nettype wire

// ---- dv/cgr_gate_regs_monitor.sv ----
/* Checker for the clock gate register bank.
   Assumes it is bound to cgr_gate_regs and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module cgr_gate_regs_monitor
	import cgr_pkg::*;
(
	// Clock, reset and register writes
	input wire logic                    CLK_I,
	input wire logic                    SYS_RST_I,
	input wire logic [ADDR_W-1:0]       REG_ADDR_I,
	input wire logic                    REG_WR_I,
	input wire logic [DATA_W-1:0]       REG_WDATA_I,
	// Divider qualifiers
	input wire logic [NUM_OUT_DIVS-1:0] OUTPUT_DIVIDER_ENABLE_I,
	input wire logic [NUM_OUT_DIVS-1:0] OUTPUT_DIVIDER_POWERUP_I,
	// Watched outputs
	input wire logic [NUM_INPUTS-1:0]   PRESCALER_FRACTION_RUN_O,
	input wire logic                    FEEDBACK_FRACTION_RUN_O,
	input wire logic                    LOCK_LOSS_DETECTOR_RUN_O,
	input wire logic [NUM_INPUTS-1:0]   SIGNAL_LOSS_DETECTOR_RUN_O,
	input wire logic [NUM_MONITORS-1:0] FREQ_OFFSET_RUN_O,
	input wire logic [NUM_MONITORS-1:0] FREQ_OFFSET_DIVIDER_RUN_O,
	input wire logic [CAL_W-1:0]        CALIBRATION_BLOCK_O,
	input wire logic [CAL_W-1:0]        CALIBRATION_FORCE_O,
	input wire logic                    FEEDBACK_CALIBRATION_ALLOW_O,
	input wire logic [NUM_OUT_DIVS-1:0] OUTPUT_DIVIDER_RUN_O,
	input wire logic                    FEEDBACK_DIVIDER_RUN_O,
	input wire logic [DATA_W-1:0]       SPARE_UPDATE_A_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	sequence s_wr(logic [ADDR_W-1:0] a);
		REG_WR_I && REG_ADDR_I == a;
	endsequence
	// ============================================================
	// Assertions
	AST_PRESC_FRAC: assert property (s_wr(OFS_FRACTIONAL_GATES) |-> ##2 PRESCALER_FRACTION_RUN_O == ~$past(REG_WDATA_I[3:0], 2))
		else $error("prescaler fraction run wrong");
	AST_FB_FRAC: assert property (s_wr(OFS_FRACTIONAL_GATES) |-> ##2 FEEDBACK_FRACTION_RUN_O == !$past(REG_WDATA_I[5], 2))
		else $error("feedback fraction run wrong");
	AST_LOCK: assert property (s_wr(OFS_LOCK_LOSS_GATE) |-> ##2 LOCK_LOSS_DETECTOR_RUN_O == !$past(REG_WDATA_I[1], 2))
		else $error("lock loss run wrong");
	AST_SIG: assert property (s_wr(OFS_SIGNAL_LOSS_GATES) |-> ##2 SIGNAL_LOSS_DETECTOR_RUN_O == ~$past(REG_WDATA_I[3:0], 2))
		else $error("signal loss run wrong");
	AST_FOFS: assert property (s_wr(OFS_FREQ_OFFSET_GATES) |-> ##2 FREQ_OFFSET_RUN_O == ~$past(REG_WDATA_I[4:0], 2))
		else $error("offset monitor run wrong");
	AST_FOFS_DIV: assert property (s_wr(OFS_FREQ_OFFSET_DIV_GATES) |-> ##2 FREQ_OFFSET_DIVIDER_RUN_O == ~$past(REG_WDATA_I[4:0], 2))
		else $error("offset divider run wrong");
	AST_CAL: assert property (s_wr(OFS_CALIBRATION_OVERRIDE) |=> {CALIBRATION_FORCE_O, CALIBRATION_BLOCK_O} == $past(REG_WDATA_I[3:0]))
		else $error("calibration fields wrong");
	AST_DIV_GATE: assert property (s_wr(OFS_DIVIDER_GATES) |-> ##2 OUTPUT_DIVIDER_RUN_O == ($past(OUTPUT_DIVIDER_ENABLE_I & OUTPUT_DIVIDER_POWERUP_I) & ~$past(REG_WDATA_I[4:0], 2)))
		else $error("output divider run wrong after gate write");
	AST_DIV_QUAL: assert property ((OUTPUT_DIVIDER_RUN_O & ~$past(OUTPUT_DIVIDER_ENABLE_I & OUTPUT_DIVIDER_POWERUP_I)) == '0)
		else $error("output divider runs without enable and powerup");
	AST_FB_DIV: assert property (s_wr(OFS_DIVIDER_GATES) |-> ##2 FEEDBACK_DIVIDER_RUN_O == !$past(REG_WDATA_I[5], 2))
		else $error("feedback divider run wrong");
	AST_FB_CAL: assert property (s_wr(OFS_DIVIDER_GATES) |=> FEEDBACK_CALIBRATION_ALLOW_O == !$past(REG_WDATA_I[6]))
		else $error("feedback calibration allow wrong");
	AST_SPARE: assert property (s_wr(OFS_SPARE_UPDATE_A) |=> SPARE_UPDATE_A_O == $past(REG_WDATA_I))
		else $error("spare byte wrong");
	AST_STEADY: assert property (!$past(REG_WR_I, 2) && !$past(SYS_RST_I) |-> $stable(LOCK_LOSS_DETECTOR_RUN_O) && $stable(PRESCALER_FRACTION_RUN_O))
		else $error("gate changed without a write");
	// ============================================================
	// Coverage
	COV_DIV: cover property (s_wr(OFS_DIVIDER_GATES));
	COV_B2B: cover property (s_wr(OFS_FRACTIONAL_GATES) ##1 s_wr(OFS_LOCK_LOSS_GATE));
	COV_STOP: cover property ($fell(OUTPUT_DIVIDER_RUN_O[0]));
endmodule // cgr_gate_regs_monitor
bind cgr_gate_regs cgr_gate_regs_monitor cgr_gate_regs_monitor_inst (.CLK_I, .SYS_RST_I, .REG_ADDR_I, .REG_WR_I,
	.REG_WDATA_I, .OUTPUT_DIVIDER_ENABLE_I, .OUTPUT_DIVIDER_POWERUP_I, .PRESCALER_FRACTION_RUN_O,
	.FEEDBACK_FRACTION_RUN_O, .LOCK_LOSS_DETECTOR_RUN_O, .SIGNAL_LOSS_DETECTOR_RUN_O, .FREQ_OFFSET_RUN_O,
	.FREQ_OFFSET_DIVIDER_RUN_O, .CALIBRATION_BLOCK_O, .CALIBRATION_FORCE_O, .FEEDBACK_CALIBRATION_ALLOW_O,
	.OUTPUT_DIVIDER_RUN_O, .FEEDBACK_DIVIDER_RUN_O, .SPARE_UPDATE_A_O);
`default_nettype wire

// ---- dv/tb_cgr_gate_regs.sv ----
/* Self-checking bench for the clock gate register bank.
   Assumes cgr_pkg, the design and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_cgr_gate_regs;
	import cgr_pkg::*;
	// ============================================================
	// Signals
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00, rdata, spa, spb, per;
	logic [4:0]  en = 5'h00, pu = 5'h00, fofs, fdiv, drun;
	logic [3:0]  presc, sig, skip;
	logic [2:0]  ctl0;
	logic [1:0]  calb, calf;
	logic [11:0] code;
	logic        fbf, lock, allow, fbdiv, out4, ctl1, von;
	int          error_cnt = 0, cmp_count = 0;
	logic [15:0] ofs [16] = '{OFS_OUT4_LOAD_AUTODISABLE, OFS_SPARE_UPDATE_A, OFS_SPARE_UPDATE_B, OFS_FRACTIONAL_GATES,
		OFS_LOCK_LOSS_GATE, OFS_SIGNAL_LOSS_GATES, OFS_FREQ_OFFSET_GATES, OFS_FREQ_OFFSET_DIV_GATES,
		OFS_CALIBRATION_OVERRIDE, OFS_DIVIDER_GATES, OFS_OSC_CAL_CODE_LOW, OFS_OSC_CAL_CODE_HIGH,
		OFS_VALIDATION_DIV_CTRL, OFS_VALIDATION_PWRUP_SKIP, OFS_INPUT_VALIDATION_ON, OFS_INPUT_VALIDATION_TIME};
	logic [7:0]  msk [16] = '{8'h08, 8'hff, 8'hff, 8'h2f, 8'h02, 8'h0f, 8'h1f, 8'h1f,
		8'h0f, 8'h7f, 8'hff, 8'h0f, 8'h17, 8'h0f, 8'h01, 8'hff};
	always #12.5 clk = ~clk;
	cgr_gate_regs cgr_gate_regs_inst (.CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
		.REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .OUTPUT_DIVIDER_ENABLE_I(en),
		.OUTPUT_DIVIDER_POWERUP_I(pu), .PRESCALER_FRACTION_RUN_O(presc), .FEEDBACK_FRACTION_RUN_O(fbf),
		.LOCK_LOSS_DETECTOR_RUN_O(lock), .SIGNAL_LOSS_DETECTOR_RUN_O(sig), .FREQ_OFFSET_RUN_O(fofs),
		.FREQ_OFFSET_DIVIDER_RUN_O(fdiv), .CALIBRATION_BLOCK_O(calb), .CALIBRATION_FORCE_O(calf),
		.FEEDBACK_CALIBRATION_ALLOW_O(allow), .OUTPUT_DIVIDER_RUN_O(drun), .FEEDBACK_DIVIDER_RUN_O(fbdiv),
		.OUT4_LOAD_AUTODISABLE_O(out4), .SPARE_UPDATE_A_O(spa), .SPARE_UPDATE_B_O(spb),
		.OSCILLATOR_CAL_CODE_O(code), .VALIDATION_DIV_CTRL0_O(ctl0), .VALIDATION_DIV_CTRL1_O(ctl1),
		.VALIDATION_POWERUP_SKIP_O(skip), .INPUT_VALIDATION_ON_O(von), .INPUT_VALIDATION_PERIOD_O(per));
	// ============================================================
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
	endtask
	task automatic idle(input int n);
		@(posedge clk);
		wr <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic do_reset(input int n);
		@(posedge clk);
		rst <= 1'b1;
		wr <= 1'b0;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		idle(2);
	endtask
	// Outputs and readback for a byte p held in every register
	task automatic check_all(input logic [7:0] p);
		logic [7:0] q;
		q = ~p;
		chk(presc, q[3:0]);
		chk(fbf, q[5]);
		chk(lock, q[1]);
		chk(sig, q[3:0]);
		chk(fofs, q[4:0]);
		chk(fdiv, q[4:0]);
		chk({calf, calb}, p[3:0]);
		chk(drun, en & pu & q[4:0]);
		chk(fbdiv, q[5]);
		chk(allow, q[6]);
		chk({spb, spa}, {p, p});
		chk(code, {p[3:0], p});
		chk({out4, ctl1, ctl0}, {p[3], p[4], p[2:0]});
		chk({skip, von, per}, {p[3:0], p[0], p});
		for (int i = 0; i < 16; i++) rd_reg(ofs[i], p & msk[i]);
	endtask
	task automatic apply(input logic [7:0] p, input logic [4:0] e, input logic [4:0] u);
		for (int i = 0; i < 16; i++) wr_reg(ofs[i], p);
		en <= e;
		pu <= u;
		idle(2);
		check_all(p);
	endtask
	// ============================================================
	// Sequence
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		do_reset(8);
		check_all(8'h00);
		apply(8'hff, 5'h1f, 5'h1f);
		apply(8'ha5, 5'h1f, 5'h1f);
		apply(8'h5a, 5'h1e, 5'h1b);
		wr_reg(16'h0b4b, 8'hff);
		wr_reg(16'h0000, 8'hff);
		idle(2);
		rd_reg(16'h0b4b, 8'h00);
		check_all(8'h5a);
		apply(8'h00, 5'h17, 5'h0d);
		apply(8'hff, 5'h1f, 5'h1f);
		do_reset(3);
		check_all(8'h00);
		print_verdict();
	end
endmodule // tb_cgr_gate_regs
`default_nettype wire
